// ==== core/fwp_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - disable bit 0 programmed with enable bit 0 erased makes flash unprotected
// - disable bit 0 programmable only after debug and access bits
// - disable bit x programmable only after enable bit x-1
// - enable bit x with next disable erased restores access protection
// - enable bit x programmable only after disable bit x
// - protected primary flash data only reachable from primary flash code
// - at most sixteen disable then re-enable pairs
// - protected reads from RAM code give dummy data, writes dropped
// - peripheral event transfers blocked on protected flash
// - extension flash never access protected
// - foreign fetch denies primary data reads and register writes
// - sector write-protect bit at 0 inhibits writes to that sector
// - set-protection writing 1 temporarily clears sector protection
// - access bit temporary clear honoured only from flash code
// - reset or writing 0 restores temporary cleared protections
// - another bank may update protected flash without unprotection
// - temporary clear touches only volatile state, stored bits remain
// - debug bit at 0 disables debug; erased, debug bypasses protection
module fwp_top #(
  parameter int CHAIN_LEN = fwp_pkg::CHAIN_MAX
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire fwp_pkg::fwp_img_t NV_WORDS,
  input wire fwp_pkg::fwp_spr_req_t SPR_REQ,
  output var fwp_pkg::fwp_spr_rsp_t SPR_RSP,
  output var fwp_pkg::fwp_img_t NV_WR_IMAGE,
  output logic [fwp_pkg::NUM_WORDS-1:0] NV_WR_MASK,
  input wire fwp_pkg::fwp_acc_req_t ACC_REQ,
  output var fwp_pkg::fwp_acc_rsp_t ACC_RSP,
  output logic DEBUG_ENABLE,
  output logic PROT_READY
);
  import fwp_pkg::*;

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (CHAIN_LEN < 1 || CHAIN_LEN > CHAIN_MAX) begin : g_bad_len
    $error("CHAIN_LEN must be 1 to 16");
  end

  fwp_state_t state_r, state_nxt;
  fwp_img_t vol_r, vol_nxt;
  fwp_img_t img_r, img_nxt;
  logic [NUM_WORDS-1:0] mask_r, mask_nxt;
  fwp_spr_rsp_t spr_r, spr_nxt;
  fwp_acc_rsp_t acc_r, acc_nxt;
  logic ready_r, ready_nxt;
  logic dbg_r, dbg_nxt;
  logic [15:0] dis_bits, en_bits;
  logic [15:0] pds_ok, pen_ok, cell_dis;
  logic gate0, chain_dis, ap_eff, dbg_en;
  logic spr_ifl, spr_flash, spr_win;
  logic [2:0] spr_idx;
  logic acc_ifl, wp_ok, bypass;
  logic [2:0] wp_word;
  logic hit_w;
  logic [15:0] d, dv, prog, okv;

  // ---------------------------------------------------------------
  // permanent disable / re-enable chain
  // ---------------------------------------------------------------
  assign dis_bits = NV_WORDS[IDX_DIS];
  assign en_bits = NV_WORDS[IDX_EN];
  // first disable needs debug and access bits both programmed
  assign gate0 = ~NV_WORDS[IDX_ACC][ACCESS_PROTECT_BIT_POS] &
                 ~NV_WORDS[IDX_ACC][DEBUG_PROTECT_BIT_POS];

  genvar gx;
  generate
    for (gx = 0; gx < CHAIN_MAX; gx++) begin : g_chain
      if (gx < CHAIN_LEN) begin : g_cell
        // one pair per permanent cycle
        fwp_chain_cell u_cell (
          .dis_bit(dis_bits[gx]),
          .en_bit(en_bits[gx]),
          .prev_ok((gx == 0) ? gate0 : ~en_bits[(gx == 0) ? 0 : gx - 1]),
          .dis_active(cell_dis[gx]),
          .dis_prog_ok(pds_ok[gx]),
          .en_prog_ok(pen_ok[gx])
        );
      end else begin : g_none
        // pairs beyond the chain can never be programmed
        assign cell_dis[gx] = 1'b0;
        assign pds_ok[gx] = 1'b0;
        assign pen_ok[gx] = 1'b0;
      end
    end
  endgenerate

  // a completed re-enable leaves no live pair behind it
  assign chain_dis = |cell_dis;
  // effective access protection from the volatile access bit and the stored chain
  assign ap_eff = ~vol_r[IDX_ACC][ACCESS_PROTECT_BIT_POS] & ~chain_dis;
  // erased debug bit leaves debug features open
  assign dbg_en = vol_r[IDX_ACC][DEBUG_PROTECT_BIT_POS];

  // ---------------------------------------------------------------
  // set-protection decode
  // ---------------------------------------------------------------
  assign spr_ifl = (SPR_REQ.src == SRC_IFL_B0) ||
                   (SPR_REQ.src == SRC_IFL_B1);
  assign spr_flash = spr_ifl || (SPR_REQ.src == SRC_XFL);
  assign spr_win = (SPR_REQ.addr[23:4] == PROT_BASE[23:4]);
  assign spr_idx = SPR_REQ.addr[3:1];

  // load, set-protection and stored-bit programming
  always_comb begin
    state_nxt = state_r;
    vol_nxt = vol_r;
    img_nxt = img_r;
    mask_nxt = '0;
    spr_nxt = '0;
    hit_w = 1'b0;
    d = 16'h0000;
    dv = 16'h0000;
    prog = 16'h0000;
    okv = 16'h0000;
    case (state_r)
      ST_LOAD: begin
        // volatile copy taken before any access is judged
        vol_nxt = NV_WORDS;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (SPR_REQ.valid) begin
          spr_nxt.done = 1'b1;
          if (ap_eff && !spr_ifl) begin
            spr_nxt.refused = 1'b1;
          end else if (spr_win) begin
            img_nxt = NV_WORDS;
            for (int w = 0; w < NUM_WORDS; w++) begin
              hit_w = (3'(w) == spr_idx);
              d = SPR_REQ.data[15:0];
              if (!SPR_REQ.addr[1] && 3'(w) == 3'(spr_idx + 3'h1)) begin
                hit_w = 1'b1;
                d = SPR_REQ.data[31:16];
              end
              okv = (3'(w) == IDX_DIS) ? pds_ok : pen_ok;
              prog = ~d & NV_WORDS[w];
              dv = d;
              if (hit_w && (3'(w) == IDX_DIS || 3'(w) == IDX_EN)) begin
                // chain bits only go to 0 in their legal order
                if ((prog & ~okv) != 16'h0000) begin
                  spr_nxt.refused = 1'b1;
                end
                prog = prog & okv;
                img_nxt[w] = NV_WORDS[w] & ~prog;
                mask_nxt[w] = |prog;
              end else if (hit_w && 3'(w) != IDX_SPARE) begin
                // non-flash code may restore the access bit, never clear it
                if (3'(w) == IDX_ACC && !spr_flash) begin
                  dv[ACCESS_PROTECT_BIT_POS] = vol_r[w][ACCESS_PROTECT_BIT_POS] & d[ACCESS_PROTECT_BIT_POS];
                end
                img_nxt[w] = NV_WORDS[w] & d;
                mask_nxt[w] = |prog;
                // 1 clears temporarily, 0 restores; stored bits keep 0
                vol_nxt[w] = dv;
              end
            end
          end
        end
      end
      default: begin
        state_nxt = ST_LOAD;
      end
    endcase
    ready_nxt = (state_nxt == ST_RUN);
    dbg_nxt = (state_nxt == ST_RUN) & vol_nxt[IDX_ACC][DEBUG_PROTECT_BIT_POS];
  end

  // protection state registers
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_LOAD;
      vol_r <= {NUM_WORDS{VOL_RESET}};
      img_r <= {NUM_WORDS{WORD_ERASED}};
      mask_r <= '0;
      spr_r <= '0;
      ready_r <= 1'b0;
      dbg_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      vol_r <= vol_nxt;
      img_r <= img_nxt;
      mask_r <= mask_nxt;
      spr_r <= spr_nxt;
      ready_r <= ready_nxt;
      dbg_r <= dbg_nxt;
    end
  end

  // ---------------------------------------------------------------
  // access check
  // ---------------------------------------------------------------
  assign acc_ifl = (ACC_REQ.src == SRC_IFL_B0) ||
                   (ACC_REQ.src == SRC_IFL_B1);
  assign bypass = ACC_REQ.debug & dbg_en;

  // sector bit of the addressed bank
  always_comb begin
    case (ACC_REQ.bank)
      2'h0: wp_word = IDX_PRIM_LO;
      2'h1: wp_word = IDX_PRIM_HI;
      2'h2: wp_word = IDX_EXT_LO;
      default: wp_word = IDX_EXT_HI;
    endcase
    wp_ok = vol_r[wp_word][ACC_REQ.sector];
  end

  // grant, dummy read and write-protect verdict
  always_comb begin
    acc_nxt = '0;
    if (ACC_REQ.valid) begin
      acc_nxt.done = 1'b1;
      acc_nxt.grant = 1'b1;
      if (state_r != ST_RUN) begin
        acc_nxt.grant = 1'b0;
      end else if (!bypass) begin
        case (ACC_REQ.tgt)
          TGT_IFL_DATA: begin
            if (ap_eff && ACC_REQ.peripheral_event_transfer) begin
              acc_nxt.grant = 1'b0;
            end else if (ap_eff && !acc_ifl) begin
              // another bank may still update the module
              acc_nxt.grant = ACC_REQ.wr &&
                              (ACC_REQ.src == SRC_XFL);
            end
          end
          TGT_IFL_JUMP: acc_nxt.grant = 1'b1;
          TGT_XFL: acc_nxt.grant = 1'b1;
          TGT_REGS: begin
            if (ap_eff && ACC_REQ.wr && !acc_ifl) begin
              acc_nxt.grant = 1'b0;
            end
          end
          default: acc_nxt.grant = 1'b0;
        endcase
        // protected sector swallows the write
        if (acc_nxt.grant && ACC_REQ.wr && !wp_ok &&
            (ACC_REQ.tgt == TGT_IFL_DATA || ACC_REQ.tgt == TGT_XFL)) begin
          acc_nxt.grant = 1'b0;
          acc_nxt.wp_block = 1'b1;
        end
      end
      // refused primary flash data reads return dummy data, refused writes are dropped
      acc_nxt.dummy = !acc_nxt.grant && !ACC_REQ.wr &&
                      (ACC_REQ.tgt == TGT_IFL_DATA);
    end
  end

  // access verdict register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  assign SPR_RSP = spr_r;
  assign NV_WR_IMAGE = img_r;
  assign NV_WR_MASK = mask_r;
  assign ACC_RSP = acc_r;
  assign DEBUG_ENABLE = dbg_r;
  assign PROT_READY = ready_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  a_load_first: assert property (
    state_r == ST_LOAD |=> PROT_READY && vol_r == $past(NV_WORDS))
    else $error("volatile state not loaded at start");
  a_ram_dummy: assert property (
    ACC_REQ.valid && state_r == ST_RUN && ap_eff && !bypass &&
    ACC_REQ.tgt == TGT_IFL_DATA && !ACC_REQ.wr &&
    ACC_REQ.src == SRC_INTERNAL_RAM |=> ACC_RSP.done && !ACC_RSP.grant &&
    ACC_RSP.dummy)
    else $error("protected read from ram not dummied");
  a_pec_block: assert property (
    ACC_REQ.valid && ap_eff && !bypass && ACC_REQ.peripheral_event_transfer &&
    ACC_REQ.tgt == TGT_IFL_DATA |=> !ACC_RSP.grant)
    else $error("event transfer reached protected flash");
  a_xfl_open: assert property (
    ACC_REQ.valid && state_r == ST_RUN && ACC_REQ.tgt == TGT_XFL &&
    !ACC_REQ.wr |=> ACC_RSP.grant)
    else $error("extension flash read refused");
  a_self_read: assert property (
    ACC_REQ.valid && state_r == ST_RUN && acc_ifl && !ACC_REQ.wr &&
    !ACC_REQ.peripheral_event_transfer && ACC_REQ.tgt == TGT_IFL_DATA |=> ACC_RSP.grant)
    else $error("primary flash code denied own data");
  a_reg_wr_deny: assert property (
    ACC_REQ.valid && ap_eff && !bypass && ACC_REQ.wr &&
    ACC_REQ.tgt == TGT_REGS && !acc_ifl |=> !ACC_RSP.grant)
    else $error("foreign register write granted");
  a_sector_wp: assert property (
    ACC_REQ.valid && state_r == ST_RUN && !bypass && acc_ifl &&
    ACC_REQ.wr && !ACC_REQ.peripheral_event_transfer && !wp_ok &&
    ACC_REQ.tgt == TGT_IFL_DATA |=> ACC_RSP.wp_block && !ACC_RSP.grant)
    else $error("write into protected sector");
  a_first_gate: assert property (
    SPR_REQ.valid && state_r == ST_RUN && !ap_eff && !gate0 &&
    SPR_REQ.addr == PROT_DISABLE_OFS && !SPR_REQ.data[0] &&
    dis_bits[0] |=> SPR_RSP.refused && NV_WR_IMAGE[IDX_DIS][0])
    else $error("first disable programmed without gate");
  a_en_order: assert property (
    SPR_REQ.valid && state_r == ST_RUN && spr_ifl &&
    SPR_REQ.addr == PROT_REENABLE_OFS && !SPR_REQ.data[0] &&
    en_bits[0] && dis_bits[0] |=> SPR_RSP.refused && NV_WR_IMAGE[IDX_EN][0])
    else $error("enable programmed before its disable");
  a_chain_open: assert property (
    PROT_READY && !dis_bits[0] && en_bits[0] && !ACC_REQ.wr && ACC_REQ.valid &&
    ACC_REQ.tgt == TGT_IFL_DATA && !ACC_REQ.peripheral_event_transfer |=> ACC_RSP.grant)
    else $error("live chain pair did not lift protection");
  a_temp_clear: assert property (
    SPR_REQ.valid && state_r == ST_RUN && spr_ifl &&
    SPR_REQ.addr == PRIM_SECT_OFS && SPR_REQ.data[0] |=>
    vol_r[IDX_PRIM_LO][0] && !NV_WR_MASK[IDX_PRIM_LO] ||
    !$past(NV_WORDS[IDX_PRIM_LO][0]) == 1'b0)
    else $error("sector not temporarily cleared");

  c_dummy: cover property (ACC_RSP.dummy);
  c_wp_block: cover property (ACC_RSP.wp_block);
  c_chain_dis: cover property (state_r == ST_RUN && chain_dis);
  c_refused: cover property (SPR_RSP.refused);

endmodule
`default_nettype wire

// ==== shared/fwp_pkg.sv ====
`default_nettype none
package fwp_pkg;

  // ---------------------------------------------------------------
  // protection word map
  // ---------------------------------------------------------------
  localparam int NUM_WORDS = 8;
  localparam int CHAIN_MAX = 16;
  localparam logic [23:0] PROT_BASE = 24'h0edfb0;
  localparam logic [23:0] EXT_SECT_OFS = 24'h0edfb0;
  localparam logic [23:0] PRIM_SECT_OFS = 24'h0edfb4;
  localparam logic [23:0] ACCESS_WORD_OFS = 24'h0edfb8;
  localparam logic [23:0] SPARE_WORD_OFS = 24'h0edfba;
  localparam logic [23:0] PROT_DISABLE_OFS = 24'h0edfbc;
  localparam logic [23:0] PROT_REENABLE_OFS = 24'h0edfbe;

  // 16-bit word index inside the window
  localparam logic [2:0] IDX_EXT_LO = 3'((EXT_SECT_OFS - PROT_BASE) >> 1);
  localparam logic [2:0] IDX_EXT_HI = 3'(IDX_EXT_LO + 3'h1);
  localparam logic [2:0] IDX_PRIM_LO = 3'((PRIM_SECT_OFS - PROT_BASE) >> 1);
  localparam logic [2:0] IDX_PRIM_HI = 3'(IDX_PRIM_LO + 3'h1);
  localparam logic [2:0] IDX_ACC = 3'((ACCESS_WORD_OFS - PROT_BASE) >> 1);
  localparam logic [2:0] IDX_SPARE = 3'((SPARE_WORD_OFS - PROT_BASE) >> 1);
  localparam logic [2:0] IDX_DIS = 3'((PROT_DISABLE_OFS - PROT_BASE) >> 1);
  localparam logic [2:0] IDX_EN = 3'((PROT_REENABLE_OFS - PROT_BASE) >> 1);

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ACCESS_PROTECT_BIT_POS = 0;
  localparam int DEBUG_PROTECT_BIT_POS = 1;
  localparam logic [15:0] WORD_ERASED = 16'hffff;
  localparam logic [15:0] VOL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [NUM_WORDS-1:0][15:0] fwp_img_t;

  typedef enum logic [2:0] {
    SRC_IFL_B0 = 3'h0,
    SRC_IFL_B1 = 3'h1,
    SRC_XFL = 3'h2,
    SRC_INTERNAL_RAM = 3'h3,
    SRC_EXTENSION_RAM = 3'h4,
    SRC_EXT = 3'h5
  } fwp_src_t;

  typedef enum logic [1:0] {
    TGT_IFL_DATA = 2'h0,
    TGT_IFL_JUMP = 2'h1,
    TGT_XFL = 2'h2,
    TGT_REGS = 2'h3
  } fwp_tgt_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } fwp_state_t;

  typedef struct packed {
    logic valid;
    fwp_src_t src;
    logic [23:0] addr;
    logic [31:0] data;
  } fwp_spr_req_t;

  typedef struct packed {
    logic done;
    logic refused;
  } fwp_spr_rsp_t;

  typedef struct packed {
    logic valid;
    fwp_src_t src;
    fwp_tgt_t tgt;
    logic wr;
    logic peripheral_event_transfer;
    logic debug;
    logic [1:0] bank;
    logic [3:0] sector;
  } fwp_acc_req_t;

  typedef struct packed {
    logic done;
    logic grant;
    logic dummy;
    logic wp_block;
  } fwp_acc_rsp_t;

endpackage
`default_nettype wire

// ==== core/fwp_chain_cell.sv ====
`timescale 1ns/10ps
`default_nettype none
module fwp_chain_cell (
  input wire logic dis_bit,
  input wire logic en_bit,
  input wire logic prev_ok,
  output logic dis_active,
  output logic dis_prog_ok,
  output logic en_prog_ok
);

  // ---------------------------------------------------------------
  // one disable / re-enable pair of the permanent chain
  // ---------------------------------------------------------------
  // pair is live while disable is programmed and enable still erased
  assign dis_active = ~dis_bit & en_bit;
  // disable needs the previous stage completed
  assign dis_prog_ok = prev_ok;
  // enable needs its own disable programmed first
  assign en_prog_ok = ~dis_bit;

endmodule
`default_nettype wire

// ==== tb/fwp_nv_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fwp_nv_model (
  input wire logic clk,
  input wire logic preset,
  input wire fwp_pkg::fwp_img_t wr_img,
  input wire logic [fwp_pkg::NUM_WORDS-1:0] wr_mask,
  output var fwp_pkg::fwp_img_t words
);
  import fwp_pkg::*;

  // ------------------------------------------------------------
  // stored protection cells
  // ------------------------------------------------------------
  // programming only clears bits, a written 1 never erases a cell
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      if (preset) begin
        words[i] <= WORD_ERASED;
      end else if (wr_mask[i]) begin
        words[i] <= words[i] & wr_img[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/flash_access_write_protection_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_access_write_protection_bench;
  import fwp_pkg::*;

  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  localparam int LEN = 2;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic preset = 1'b1;
  fwp_img_t nv_words;
  fwp_img_t wr_img;
  logic [NUM_WORDS-1:0] wr_mask;
  fwp_spr_req_t spr_req = '0;
  fwp_spr_rsp_t spr_rsp;
  fwp_acc_req_t acc_req = '0;
  fwp_acc_rsp_t acc_rsp;
  logic dbg_en;
  logic ready;
  fwp_spr_rsp_t s_rsp;
  logic [NUM_WORDS-1:0] s_mask;
  fwp_img_t s_img;
  fwp_acc_rsp_t a_rsp;
  logic prim;
  logic exp_g;
  logic [15:0] chain;
  int mismatches = 0;
  int checked = 0;

  // 50 ns period
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  fwp_top #(.CHAIN_LEN(LEN)) u_dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .NV_WORDS(nv_words),
    .SPR_REQ(spr_req), .SPR_RSP(spr_rsp), .NV_WR_IMAGE(wr_img),
    .NV_WR_MASK(wr_mask), .ACC_REQ(acc_req), .ACC_RSP(acc_rsp),
    .DEBUG_ENABLE(dbg_en), .PROT_READY(ready)
  );

  fwp_nv_model u_nv (
    .clk(sys_clk), .preset(preset), .wr_img(wr_img),
    .wr_mask(wr_mask), .words(nv_words)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    $display("[FAIL] %0t no answer", $time);
    tally_and_finish();
  endtask

  // one judged access, pulse then wait for done
  task automatic access(input fwp_src_t s, input fwp_tgt_t t,
                        input logic w, input logic p, input logic d,
                        input logic [3:0] sec);
    int n;
    @(negedge sys_clk);
    acc_req <= '{valid: 1'b1, src: s, tgt: t, wr: w, peripheral_event_transfer: p, debug: d,
                 bank: (t == TGT_XFL) ? 2'h2 : 2'h0, sector: sec};
    @(negedge sys_clk);
    acc_req.valid <= 1'b0;
    n = 0;
    while (acc_rsp.done !== 1'b1) begin
      n++;
      if (n > 6) give_up();
      @(negedge sys_clk);
    end
    a_rsp = acc_rsp;
  endtask

  // set-protection start, capture answer, let stored cells update
  task automatic set_protection_select(input fwp_src_t s, input logic [23:0] a,
                     input logic [31:0] dat);
    int n;
    @(negedge sys_clk);
    spr_req <= '{valid: 1'b1, src: s, addr: a, data: dat};
    @(negedge sys_clk);
    spr_req.valid <= 1'b0;
    n = 0;
    while (spr_rsp.done !== 1'b1) begin
      n++;
      if (n > 6) give_up();
      @(negedge sys_clk);
    end
    s_rsp = spr_rsp;
    s_mask = wr_mask;
    s_img = wr_img;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic ram_read(input logic exp);
    access(SRC_INTERNAL_RAM, TGT_IFL_DATA, 1'b0, 1'b0, 1'b0, 4'h0);
    chk(a_rsp.grant, exp, "ram read");
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    preset = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(ready, 1'b1, "ready");
    chk(dbg_en, 1'b1, "debug open");
    ram_read(1'b1);
    set_protection_select(SRC_IFL_B0, PROT_DISABLE_OFS, 32'hfffffffe);
    chk(s_rsp.refused, 1'b1, "early disable");
    set_protection_select(SRC_IFL_B0, ACCESS_WORD_OFS, 32'hfffffffc);
    chk(s_mask[IDX_ACC], 1'b1, "protect mask");
    chk(nv_words[IDX_ACC], 16'hfffc, "protect stored");
    chk(dbg_en, 1'b0, "debug closed");
    access(SRC_INTERNAL_RAM, TGT_IFL_DATA, 1'b0, 1'b0, 1'b1, 4'h0);
    chk(a_rsp.grant, 1'b0, "debug bypass gone");
    // fetch source versus target table, protections on
    for (int s = 0; s < 6; s++) begin
      for (int t = 0; t < 4; t++) begin
        for (int w = 0; w < 2; w++) begin
          if (w == 1 && t == 1) continue;
          prim = (s < 2);
          case (t)
            0: exp_g = w ? (prim || s == 2) : prim;
            3: exp_g = w ? prim : 1'b1;
            default: exp_g = 1'b1;
          endcase
          access(fwp_src_t'(s), fwp_tgt_t'(t), w[0], 1'b0, 1'b0,
                 4'h0);
          chk(a_rsp.grant, exp_g, "table");
          chk(a_rsp.dummy, !w && t == 0 && !prim, "dummy");
        end
      end
    end
    access(SRC_IFL_B0, TGT_IFL_DATA, 1'b0, 1'b1, 1'b0, 4'h0);
    chk(a_rsp.grant, 1'b0, "pec blocked");
    set_protection_select(SRC_INTERNAL_RAM, PRIM_SECT_OFS, 32'hfffffff0);
    chk(s_rsp.refused, 1'b1, "foreign spr");
    set_protection_select(SRC_INTERNAL_RAM, ACCESS_WORD_OFS, 32'hffffffff);
    chk(s_rsp.refused, 1'b1, "ram unprotect");
    ram_read(1'b0);
    // temporary clear from flash, then restore by writing 0 from ram
    set_protection_select(SRC_IFL_B0, ACCESS_WORD_OFS, 32'hffffffff);
    chk(s_mask[IDX_ACC], 1'b0, "temp no program");
    chk(nv_words[IDX_ACC], 16'hfffc, "stored kept");
    ram_read(1'b1);
    set_protection_select(SRC_INTERNAL_RAM, ACCESS_WORD_OFS, 32'hfffffffc);
    chk(s_rsp.refused, 1'b0, "ram restore");
    ram_read(1'b0);
    // sector write protection
    set_protection_select(SRC_IFL_B0, PRIM_SECT_OFS, 32'hfffffff0);
    chk(s_img[IDX_PRIM_LO], 16'hfff0, "sector image");
    access(SRC_IFL_B0, TGT_IFL_DATA, 1'b1, 1'b0, 1'b0, 4'h1);
    chk(a_rsp.grant, 1'b0, "sector blocked");
    chk(a_rsp.wp_block, 1'b1, "sector flag");
    access(SRC_IFL_B0, TGT_IFL_DATA, 1'b1, 1'b0, 1'b0, 4'h4);
    chk(a_rsp.grant, 1'b1, "other sector");
    set_protection_select(SRC_IFL_B0, PRIM_SECT_OFS, 32'hffffffff);
    access(SRC_IFL_B0, TGT_IFL_DATA, 1'b1, 1'b0, 1'b0, 4'h1);
    chk(a_rsp.grant, 1'b1, "sector temp open");
    chk(nv_words[IDX_PRIM_LO], 16'hfff0, "sector stored");
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    access(SRC_IFL_B0, TGT_IFL_DATA, 1'b1, 1'b0, 1'b0, 4'h1);
    chk(a_rsp.grant, 1'b0, "sector after reset");
    // disable and re-enable chain
    set_protection_select(SRC_IFL_B0, PROT_REENABLE_OFS, 32'h0000fffe);
    chk(s_rsp.refused, 1'b1, "enable first");
    set_protection_select(SRC_IFL_B0, PROT_DISABLE_OFS, 32'hfffffffd);
    chk(s_rsp.refused, 1'b1, "skip disable");
    for (int x = 0; x < LEN; x++) begin
      chain = 16'hffff << (x + 1);
      set_protection_select(SRC_IFL_B0, PROT_DISABLE_OFS, {16'hffff, chain});
      chk(s_rsp.refused, 1'b0, "disable step");
      chk(nv_words[IDX_DIS], chain, "disable stored");
      ram_read(1'b1);
      // ram code may not lift the access bit even with the chain open
      set_protection_select(SRC_INTERNAL_RAM, ACCESS_WORD_OFS, 32'hffffffff);
      chk(s_rsp.refused, 1'b0, "ram clear taken");
      set_protection_select(SRC_IFL_B0, PROT_REENABLE_OFS, {16'hffff, chain});
      chk(s_rsp.refused, 1'b0, "enable step");
      ram_read(1'b0);
    end
    set_protection_select(SRC_IFL_B0, PROT_DISABLE_OFS,
        {16'hffff, 16'hffff << (LEN + 1)});
    chk(s_rsp.refused, 1'b1, "chain end");
    chk(nv_words[IDX_DIS], 16'hffff << LEN, "chain kept");
    tally_and_finish();
  end
endmodule
`default_nettype wire
